/* inc/serial_pair_pkg.sv */
// Constants and carrier types for the dual serial port pair.
// Assumes an 8-bit special-function register port driven by the MPU core.
package serial_pair_pkg;

    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_POWER_CONTROL   = 8'h87;
    localparam logic [7:0] ADDR_PORT0_CTRL      = 8'h98;
    localparam logic [7:0] ADDR_PORT0_BUFFER    = 8'h99;
    localparam logic [7:0] ADDR_PORT1_CTRL      = 8'h9B;
    localparam logic [7:0] ADDR_PORT1_BUFFER    = 8'h9C;
    localparam logic [7:0] ADDR_WDOG_BAUD       = 8'hD8;
    localparam logic [7:0] ADDR_PORT0_RELOAD_LO = 8'hAA;
    localparam logic [7:0] ADDR_PORT0_RELOAD_HI = 8'hBA;
    localparam logic [7:0] ADDR_PORT1_RELOAD_LO = 8'h9D;
    localparam logic [7:0] ADDR_PORT1_RELOAD_HI = 8'hBB;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_MODE_HI   = 7;
    localparam int BIT_MODE_LO   = 6;
    localparam int BIT_MULTIPROC = 5;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_TX_NINTH  = 3;
    localparam int BIT_RX_NINTH  = 2;
    localparam int BIT_TX_DONE   = 1;
    localparam int BIT_RX_DONE   = 0;
    localparam int BIT_RATE_DBL  = 7;
    localparam int BIT_STOP      = 1;
    localparam int BIT_IDLE      = 0;
    localparam int BIT_BAUD_SRC  = 7;

    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam logic [7:0] RESET_REG      = 8'h00;
    localparam logic [9:0] RESET_RELOAD   = 10'h3FF;
    localparam int         OVERSAMPLE     = 16;
    localparam logic [5:0] FIXED_DIV_FAST = 6'h1F;  // Clock / 32
    localparam logic [5:0] FIXED_DIV_SLOW = 6'h3F;  // Clock / 64
    localparam int         CLK_PERIOD_NS  = 10;

    // Per-port configuration, as seen by a serial engine
    typedef struct packed {
        logic       nine_bit;
        logic       fixed_rate;
        logic       multiproc;
        logic       rx_enable;
        logic       tx_ninth;
        logic       stop_bit_to_ninth;
    } port_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
    } frame_t;

endpackage : serial_pair_pkg

/* rtl/serial_engine.sv */
// One full-duplex serial port: transmitter, receiver, two-entry receive buffer.
// Assumes bit_tick pulses once per bit time from the owning block.
`timescale 1ns/1ps
module serial_engine
    import serial_pair_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      srst,
    input  wire logic                      run,
    input  wire logic                      bit_tick,
    input  wire serial_pair_pkg::port_cfg_t cfg,
    input  wire logic                      tx_load,
    input  wire logic [7:0]                tx_byte,
    output logic                           tx_done,
    output logic                           txd,
    input  wire logic                      rxd,
    output logic                           rx_valid,
    input  wire logic                      rx_ready,
    output serial_pair_pkg::frame_t        rx_frame
);
    import serial_pair_pkg::*;

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    logic [10:0] tx_shift_q;
    logic [3:0]  tx_left_q;
    logic        tx_pend_q;

    always_ff @(posedge clk_sys) begin
        tx_done <= 1'b0;
        if (srst) begin
            tx_shift_q <= '1;
            tx_left_q  <= 4'h0;
            tx_pend_q  <= 1'b0;
            txd        <= 1'b1;
        end else if (tx_load) begin
            // Stop bit, optional ninth, data LSB first, start bit
            tx_shift_q <= cfg.nine_bit ? {1'b1, cfg.tx_ninth, tx_byte, 1'b0}
                                       : {2'b11, tx_byte, 1'b0};
            tx_left_q  <= cfg.nine_bit ? 4'd11 : 4'd10;
            tx_pend_q  <= 1'b1;
        end else if (run && bit_tick && tx_left_q != 4'h0) begin
            txd        <= tx_shift_q[0];
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_left_q  <= tx_left_q - 4'h1;
        end else if (run && bit_tick && tx_pend_q) begin
            tx_pend_q <= 1'b0;
            tx_done   <= 1'b1;
        end
    end

    // ----------------------------------------
    // Receiver, sampled once per bit tick from the tick that finds the start bit low
    // ----------------------------------------
    logic [9:0] rx_shift_q;
    logic [3:0] rx_left_q;
    logic       rx_busy_q;
    logic       rx_half_q;
    logic       push;
    frame_t     push_frame;

    always_ff @(posedge clk_sys) begin
        push <= 1'b0;
        if (srst) begin
            rx_shift_q <= '0;
            rx_left_q  <= 4'h0;
            rx_busy_q  <= 1'b0;
            rx_half_q  <= 1'b0;
            push_frame <= '0;
        end else if (!cfg.rx_enable) begin
            rx_busy_q <= 1'b0;
        end else if (run && bit_tick) begin
            if (!rx_busy_q) begin
                if (!rxd) begin
                    rx_busy_q <= 1'b1;
                    rx_left_q <= cfg.nine_bit ? 4'd10 : 4'd9;
                end
            end else begin
                rx_shift_q <= {rxd, rx_shift_q[9:1]};
                rx_left_q  <= rx_left_q - 4'h1;
                if (rx_left_q == 4'h1) begin
                    rx_busy_q <= 1'b0;
                    // Ninth bit, or stop bit in 8-bit frames with multiprocessor bit clear
                    push_frame.data  <= cfg.nine_bit ? rx_shift_q[8:1] : rx_shift_q[9:2];
                    push_frame.ninth <= cfg.nine_bit ? rx_shift_q[9] : (cfg.stop_bit_to_ninth & rxd);
                    // Address filter for multiprocessor mode; rxd carries the stop bit here
                    push <= !(cfg.multiproc && cfg.nine_bit && !rx_shift_q[9]);
                end
            end
        end
    end

    // ----------------------------------------
    // Two-entry receive buffer
    // ----------------------------------------
    frame_t buf_q [2];
    logic   wr_q;
    logic   rd_q;
    logic [1:0] count_q;

    assign rx_valid = count_q != 2'd0;
    assign rx_frame = buf_q[rd_q];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            count_q <= 2'd0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            // A full buffer drops the newest frame; the older ones stay intact
            if (push && count_q != 2'd2) begin
                buf_q[wr_q] <= push_frame;
                wr_q        <= ~wr_q;
            end
            if (rx_valid && rx_ready)
                rd_q <= ~rd_q;
            count_q <= count_q + 2'((push && count_q != 2'd2) ? 1 : 0)
                               - 2'((rx_valid && rx_ready) ? 1 : 0);
        end
    end

    buf_bound_a: assert property (@(posedge clk_sys) disable iff (srst) count_q <= 2'd2)
        else $error("receive buffer overfilled");
    tx_len_a: assert property (@(posedge clk_sys) disable iff (srst)
        tx_load |=> tx_left_q >= 4'd10) else $error("transmit frame length wrong");

endmodule : serial_engine

/* rtl/dual_serial_port_pair.sv */
// Dual serial port pair: register file, baud generation and two serial engines.
// Assumes the MPU presents one-cycle register strobes on a special-function port.
//
// What this block does
// - Bytes shift least significant bit first on both lines of both ports.
// - Buffer write starts transmission; buffer read returns last received byte.
// - Both ports run independently, transmit and receive at once.
// - Baud-source bit picks timer 1 overflow or internal generator for port zero; port one always uses its generator.
// - Internal generator uses 10-bit reload from low and high registers.
// - Rates from 300 to 38400 bps, ninth-bit parity support.
// - Port zero mode 01 8-bit variable, 10 9-bit fixed, 11 9-bit variable.
// - Port zero mode 2 is 9-bit frame at clock over 32 or 64.
// - 8-bit frames carry start, eight data, one stop bit.
// - Port one mode bit 0 gives 9-bit frame, 1 gives 8-bit.
// - Rate-double bit in power control doubles the bit rate.
// - Reception runs only while the receive-enable bit is set.
// - Software bit supplies the ninth transmitted bit.
// - Ninth received bit, or stop bit in 8-bit mode with multiprocessor bit clear, captured; software clears.
// - Transmit flag set on completion, held until software clears.
// - Receive flag set on completion, held until software clears.
// - Flags ignore written ones and clear only on written zero.
// - In 9-bit frames, multiprocessor mode flags only those whose ninth bit is one.
// - Stop bit in power control halts ports until external interrupt.
`timescale 1ns/1ps
module dual_serial_port_pair
    import serial_pair_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    input  wire logic       timer1_overflow,
    input  wire logic       ext_interrupt,
    input  wire logic       port0_rxd,
    output logic            port0_txd,
    input  wire logic       port1_rxd,
    output logic            port1_txd,
    output logic            port0_irq,
    output logic            port1_irq
);
    import serial_pair_pkg::*;

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] power_control_q;
    logic [7:0] watchdog_baud_control_q;
    logic [7:0] ctrl_q [2];
    logic [9:0] reload_q [2];
    logic [1:0] tx_done_ev;
    logic [1:0] rx_pop;
    logic [1:0] rx_valid;
    frame_t     rx_frame [2];
    logic [7:0] rx_byte_q [2];

    function automatic logic hit(input logic [7:0] a);
        return sfr_wr && sfr_addr == a;
    endfunction : hit

    // Written zero clears, written one leaves alone; hardware set wins
    function automatic logic flag_next(input logic cur, input logic wr,
                                       input logic wbit, input logic set);
        return set | (cur & ~(wr & ~wbit));
    endfunction : flag_next

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            power_control_q         <= RESET_REG;
            watchdog_baud_control_q <= RESET_REG;
        end else begin
            if (hit(ADDR_POWER_CONTROL))
                power_control_q <= sfr_wdata;
            else if (ext_interrupt)
                power_control_q[BIT_STOP] <= 1'b0;
            if (hit(ADDR_WDOG_BAUD))
                watchdog_baud_control_q <= sfr_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reload_q[0] <= RESET_RELOAD;
            reload_q[1] <= RESET_RELOAD;
        end else begin
            if (hit(ADDR_PORT0_RELOAD_LO)) reload_q[0][7:0] <= sfr_wdata;
            if (hit(ADDR_PORT0_RELOAD_HI)) reload_q[0][9:8] <= sfr_wdata[1:0];
            if (hit(ADDR_PORT1_RELOAD_LO)) reload_q[1][7:0] <= sfr_wdata;
            if (hit(ADDR_PORT1_RELOAD_HI)) reload_q[1][9:8] <= sfr_wdata[1:0];
        end
    end

    logic [7:0] ctrl_addr [2];
    logic [7:0] buf_addr  [2];
    assign ctrl_addr[0] = ADDR_PORT0_CTRL;
    assign ctrl_addr[1] = ADDR_PORT1_CTRL;
    assign buf_addr[0]  = ADDR_PORT0_BUFFER;
    assign buf_addr[1]  = ADDR_PORT1_BUFFER;

    // ----------------------------------------
    // Per-port control, flags, baud, engine
    // ----------------------------------------
    logic       run;
    logic       rate_double;
    assign run         = !power_control_q[BIT_STOP];
    assign rate_double = power_control_q[BIT_RATE_DBL];

    port_cfg_t  cfg [2];
    logic [1:0] bit_tick;
    logic [1:0] txd_w;

    for (genvar p = 0; p < 2; p++) begin : g_port
        logic [9:0] baud_cnt_q;
        logic [3:0] over_q;
        logic [5:0] fix_cnt_q;
        logic       src_tick;
        logic       use_timer1;
        logic       frame_ok;

        // Port zero modes; port one mode bit inverted sense
        if (p == 0) begin : g_cfg0
            assign cfg[p].nine_bit   = ctrl_q[p][BIT_MODE_HI];
            assign cfg[p].fixed_rate = ctrl_q[p][BIT_MODE_HI] & ~ctrl_q[p][BIT_MODE_LO];
            assign frame_ok          = ctrl_q[p][BIT_MODE_HI] | ctrl_q[p][BIT_MODE_LO];
            assign use_timer1        = watchdog_baud_control_q[BIT_BAUD_SRC];
        end else begin : g_cfg1
            assign cfg[p].nine_bit   = ~ctrl_q[p][BIT_MODE_HI];
            assign cfg[p].fixed_rate = 1'b0;
            assign frame_ok          = 1'b1;
            assign use_timer1        = 1'b0;
        end
        assign cfg[p].multiproc         = ctrl_q[p][BIT_MULTIPROC];
        assign cfg[p].rx_enable         = ctrl_q[p][BIT_RX_ENABLE] & frame_ok;
        assign cfg[p].tx_ninth          = ctrl_q[p][BIT_TX_NINTH];
        assign cfg[p].stop_bit_to_ninth = ~cfg[p].nine_bit & ~ctrl_q[p][BIT_MULTIPROC];

        // Reload down-counter; doubling halves the oversample count
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                baud_cnt_q <= RESET_RELOAD;
                over_q     <= 4'h0;
                fix_cnt_q  <= 6'h00;
            end else if (run) begin
                baud_cnt_q <= (baud_cnt_q == 10'h000) ? reload_q[p] : baud_cnt_q - 10'h001;
                fix_cnt_q  <= (fix_cnt_q == 6'h00)
                            ? (rate_double ? FIXED_DIV_FAST : FIXED_DIV_SLOW) : fix_cnt_q - 6'h01;
                if (src_tick)
                    over_q <= (over_q == 4'h0)
                            ? 4'(rate_double ? OVERSAMPLE / 2 - 1 : OVERSAMPLE - 1) : over_q - 4'h1;
            end
        end

        assign src_tick    = use_timer1 ? timer1_overflow : (baud_cnt_q == 10'h000);
        assign bit_tick[p] = cfg[p].fixed_rate ? (fix_cnt_q == 6'h00) : (src_tick && over_q == 4'h0);

        // Control register with write-zero-to-clear flags
        logic rx_set;
        logic ninth_set;
        assign rx_set    = rx_pop[p];
        assign ninth_set = rx_pop[p] & rx_frame[p].ninth;
        assign rx_pop[p] = rx_valid[p] & ~ctrl_q[p][BIT_RX_DONE];

        always_ff @(posedge clk_sys) begin
            if (srst) begin
                ctrl_q[p]    <= RESET_REG;
                rx_byte_q[p] <= RESET_REG;
            end else begin
                if (hit(ctrl_addr[p]))
                    ctrl_q[p][7:3] <= sfr_wdata[7:3];
                // Ninth bit: loaded from each popped frame, also cleared by software writing zero
                ctrl_q[p][BIT_RX_NINTH] <= (rx_pop[p] ? rx_frame[p].ninth : ctrl_q[p][BIT_RX_NINTH])
                    & ~(hit(ctrl_addr[p]) & ~sfr_wdata[BIT_RX_NINTH] & ~ninth_set);
                ctrl_q[p][BIT_TX_DONE] <= flag_next(ctrl_q[p][BIT_TX_DONE], hit(ctrl_addr[p]),
                                                    sfr_wdata[BIT_TX_DONE], tx_done_ev[p]);
                ctrl_q[p][BIT_RX_DONE] <= flag_next(ctrl_q[p][BIT_RX_DONE], hit(ctrl_addr[p]),
                                                    sfr_wdata[BIT_RX_DONE], rx_set);
                if (rx_pop[p])
                    rx_byte_q[p] <= rx_frame[p].data;
            end
        end

        serial_engine u_engine (
            .clk_sys  (clk_sys),
            .srst     (srst),
            .run      (run),
            .bit_tick (bit_tick[p]),
            .cfg      (cfg[p]),
            .tx_load  (hit(buf_addr[p])),
            .tx_byte  (sfr_wdata),
            .tx_done  (tx_done_ev[p]),
            .txd      (txd_w[p]),
            .rxd      (p == 0 ? port0_rxd : port1_rxd),
            .rx_valid (rx_valid[p]),
            .rx_ready (rx_pop[p]),
            .rx_frame (rx_frame[p])
        );

        rx_flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
            rx_pop[p] |=> ctrl_q[p][BIT_RX_DONE]) else $error("receive flag not set");
        tx_flag_set_a: assert property (@(posedge clk_sys) disable iff (srst)
            tx_done_ev[p] |=> ctrl_q[p][BIT_TX_DONE]) else $error("transmit flag not set");
        flag_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
            ctrl_q[p][BIT_TX_DONE] && !(hit(ctrl_addr[p]) && !sfr_wdata[BIT_TX_DONE])
            |=> ctrl_q[p][BIT_TX_DONE]) else $error("transmit flag dropped");
        flag_ones_a: assert property (@(posedge clk_sys) disable iff (srst)
            !ctrl_q[p][BIT_RX_DONE] && !rx_pop[p] |=> !ctrl_q[p][BIT_RX_DONE])
            else $error("receive flag set without frame");
        rx_byte_a: assert property (@(posedge clk_sys) disable iff (srst)
            rx_pop[p] |=> rx_byte_q[p] == $past(rx_frame[p].data)) else $error("received byte lost");
        rx_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
            !cfg[p].rx_enable |=> !$rose(rx_valid[p])) else $error("receive while disabled");
        tx_cover_c: cover property (@(posedge clk_sys) tx_done_ev[p]);
        rx_cover_c: cover property (@(posedge clk_sys) rx_pop[p]);
    end

    assign port0_txd = txd_w[0];
    assign port1_txd = txd_w[1];
    assign port0_irq = ctrl_q[0][BIT_TX_DONE] | ctrl_q[0][BIT_RX_DONE];
    assign port1_irq = ctrl_q[1][BIT_TX_DONE] | ctrl_q[1][BIT_RX_DONE];

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sfr_rdata <= RESET_REG;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                ADDR_POWER_CONTROL:   sfr_rdata <= power_control_q;
                ADDR_WDOG_BAUD:       sfr_rdata <= watchdog_baud_control_q;
                ADDR_PORT0_CTRL:      sfr_rdata <= ctrl_q[0];
                ADDR_PORT1_CTRL:      sfr_rdata <= {ctrl_q[1][7], 1'b0, ctrl_q[1][5:0]};
                ADDR_PORT0_BUFFER:    sfr_rdata <= rx_byte_q[0];
                ADDR_PORT1_BUFFER:    sfr_rdata <= rx_byte_q[1];
                ADDR_PORT0_RELOAD_LO: sfr_rdata <= reload_q[0][7:0];
                ADDR_PORT0_RELOAD_HI: sfr_rdata <= {6'h00, reload_q[0][9:8]};
                ADDR_PORT1_RELOAD_LO: sfr_rdata <= reload_q[1][7:0];
                ADDR_PORT1_RELOAD_HI: sfr_rdata <= {6'h00, reload_q[1][9:8]};
                default:              sfr_rdata <= 8'h00;
            endcase
        end
    end

    stop_halt_a: assert property (@(posedge clk_sys) disable iff (srst)
        !run && !hit(ADDR_POWER_CONTROL) && !ext_interrupt |=> !run) else $error("stop released early");
    stop_wake_a: assert property (@(posedge clk_sys) disable iff (srst)
        !run && ext_interrupt && !hit(ADDR_POWER_CONTROL) |=> run) else $error("no wake on interrupt");
    fixed_rate_a: assert property (@(posedge clk_sys) disable iff (srst)
        cfg[0].fixed_rate && run && bit_tick[0] && !hit(ADDR_POWER_CONTROL) |-> ##1 !bit_tick[0] [*8])
        else $error("fixed rate too fast");
    stop_cover_c: cover property (@(posedge clk_sys) $fell(run));

endmodule : dual_serial_port_pair

/* test/far_end.sv */
// Far-side serial partner: sends frames into a port's receive line, captures its transmit line.
// Assumes frames aligned to bit_clk system clocks; bit_clk is set by the bench per mode.
`timescale 1ns/1ps
module far_end (
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd
);
    int bit_clk = 16;

    initial rxd = 1'b1;

    // ----------------------------------------
    // Frame tasks
    // ----------------------------------------
    // Eleven bit times: start, data, ninth (or stop), stop; line rests high after
    task automatic send(input logic [7:0] data, input logic ninth);
        logic [10:0] frame;
        frame = {2'b11, data, 1'b0};
        frame[9] = ninth;
        for (int i = 0; i < 11; i++) begin
            rxd <= frame[i];
            repeat (bit_clk) @(posedge clk_sys);
        end
    endtask : send

    // Samples mid-bit so that the edge-aligned output never races the read
    task automatic grab(output logic [7:0] data, output logic ninth, output logic stop, input logic nine);
        int n;
        n = 0;
        ninth = 1'b1;
        while (txd !== 1'b0 && n < 4000) begin
            @(posedge clk_sys);
            n++;
        end
        repeat (bit_clk / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clk) @(posedge clk_sys);
            data[i] = txd;
        end
        if (nine) begin
            repeat (bit_clk) @(posedge clk_sys);
            ninth = txd;
        end
        repeat (bit_clk) @(posedge clk_sys);
        stop = txd;
    endtask : grab
endmodule : far_end

/* test/testbench.sv */
// Self-checking bench for the dual serial port pair.
// Assumes one far_end partner per port and both reload values written to zero.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    import serial_pair_pkg::*;
    logic       clk_sys, srst, sfr_wr, sfr_rd, ninth, stop;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, r;
    logic       port0_rxd, port0_txd, port1_rxd, port1_txd, port0_irq, port1_irq;
    logic       ext_interrupt, timer1_overflow;
    int         n_fail = 0;
    int         checks = 0;

    dual_serial_port_pair i_dual_serial_port_pair (
        .clk_sys(clk_sys), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer1_overflow(timer1_overflow),
        .ext_interrupt(ext_interrupt),
        .port0_rxd(port0_rxd), .port0_txd(port0_txd), .port1_rxd(port1_rxd), .port1_txd(port1_txd),
        .port0_irq(port0_irq), .port1_irq(port1_irq));
    far_end i_far_end_0 (.clk_sys(clk_sys), .txd(port0_txd), .rxd(port0_rxd));
    far_end i_far_end_1 (.clk_sys(clk_sys), .txd(port1_txd), .rxd(port1_rxd));

    // ----------------------------------------
    // Register bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr  <= a;
        sfr_wdata <= v;
        sfr_wr    <= 1'b1;
        @(posedge clk_sys);
        sfr_wr    <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clk_sys);
        sfr_rd   <= 1'b0;
        @(posedge clk_sys);
        v = sfr_rdata;
    endtask : rd

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Port zero modes 01, 11 and 10, then rate doubling; flags probed with ones written back
    task automatic t_port0_modes;
        logic [7:0] ctl [4] = '{8'h40, 8'hC8, 8'h88, 8'hC8};
        logic [7:0] pwr [4] = '{8'h00, 8'h00, 8'h00, 8'h80};
        int         bt  [4] = '{16, 16, 64, 8};
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_POWER_CONTROL, pwr[k]);
            wr(ADDR_PORT0_CTRL, ctl[k]);
            i_far_end_0.bit_clk = bt[k];
            wr(ADDR_PORT0_BUFFER, 8'hA5 ^ k[7:0]);
            i_far_end_0.grab(d, ninth, stop, ctl[k][7]);
            `CHK(d, 8'hA5 ^ k[7:0])
            `CHK({ninth, stop}, 2'b11)
            repeat (80) @(posedge clk_sys);
            rd(ADDR_PORT0_CTRL, r);
            `CHK(r, ctl[k] | 8'h02)
            `CHK(port0_irq, 1'b1)
            wr(ADDR_PORT0_CTRL, ctl[k] | 8'h03);
            rd(ADDR_PORT0_CTRL, r);
            `CHK(r, ctl[k] | 8'h02)
            wr(ADDR_PORT0_CTRL, ctl[k]);
            rd(ADDR_PORT0_CTRL, r);
            `CHK(r, ctl[k])
        end
        wr(ADDR_POWER_CONTROL, 8'h00);
    endtask : t_port0_modes

    // Port one sends and receives a 9-bit frame at the same time
    task automatic t_port1_duplex;
        wr(ADDR_PORT1_CTRL, 8'h18);
        wr(ADDR_PORT1_BUFFER, 8'h96);
        fork
            i_far_end_1.send(8'h3C, 1'b1);
            i_far_end_1.grab(d, ninth, stop, 1'b1);
        join
        repeat (40) @(posedge clk_sys);
        `CHK({d, ninth}, 9'h12D)
        rd(ADDR_PORT1_CTRL, r);
        `CHK(r, 8'h1F)
        `CHK(port1_irq, 1'b1)
        rd(ADDR_PORT1_BUFFER, r);
        `CHK(r, 8'h3C)
        wr(ADDR_PORT1_CTRL, 8'h18);
        rd(ADDR_PORT1_CTRL, r);
        `CHK(r, 8'h18)
    endtask : t_port1_duplex

    // Multiprocessor filter, 8-bit stop capture, then reception switched off
    task automatic t_port1_filter;
        logic [7:0] ctl [4] = '{8'h30, 8'h30, 8'h90, 8'h00};
        logic [7:0] dat [4] = '{8'h55, 8'h66, 8'hC3, 8'h77};
        logic [7:0] exp [4] = '{8'h30, 8'h35, 8'h95, 8'h00};
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_PORT1_CTRL, ctl[k]);
            // 8-bit frames need a high stop bit where the ninth bit would sit
            i_far_end_1.send(dat[k], k[0] | ctl[k][7]);
            repeat (40) @(posedge clk_sys);
            rd(ADDR_PORT1_CTRL, r);
            `CHK(r, exp[k])
            if (exp[k][0] === 1'b1) begin
                rd(ADDR_PORT1_BUFFER, r);
                `CHK(r, dat[k])
            end
        end
    endtask : t_port1_filter

    // Stop freezes a loaded port zero until an interrupt; timer 1 then paces it
    task automatic t_stop_timer1;
        wr(ADDR_WDOG_BAUD, 8'h80);
        wr(ADDR_PORT0_CTRL, 8'h40);
        wr(ADDR_POWER_CONTROL, 8'h02);
        wr(ADDR_PORT0_BUFFER, 8'h5A);
        repeat (400) @(posedge clk_sys);
        rd(ADDR_PORT0_CTRL, r);
        `CHK(r, 8'h40)
        `CHK(port0_txd, 1'b1)
        ext_interrupt <= 1'b1;
        @(posedge clk_sys);
        ext_interrupt <= 1'b0;
        i_far_end_0.bit_clk = 32;
        i_far_end_0.grab(d, ninth, stop, 1'b0);
        `CHK({d, stop}, 9'h0B5)
        rd(ADDR_POWER_CONTROL, r);
        `CHK(r, 8'h00)
        wr(ADDR_WDOG_BAUD, 8'h00);
    endtask : t_stop_timer1

    task automatic close_out;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Timer 1 overflows every other clock: 32 clocks per bit when selected
    always @(posedge clk_sys) timer1_overflow <= !srst && !timer1_overflow;

    initial begin
        srst      = 1'b1;
        sfr_wr    = 1'b0;
        sfr_rd    = 1'b0;
        sfr_addr  = 8'h00;
        sfr_wdata = 8'h00;
        ext_interrupt = 1'b0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        `CHK(port0_txd, 1'b1)
        rd(8'h00, r);
        `CHK(r, 8'h00)
        // Reload zero keeps bit times short: 16 clocks, 8 when doubled
        wr(ADDR_PORT0_RELOAD_LO, 8'h00);
        wr(ADDR_PORT0_RELOAD_HI, 8'h00);
        wr(ADDR_PORT1_RELOAD_LO, 8'h00);
        wr(ADDR_PORT1_RELOAD_HI, 8'h00);
        t_port0_modes;
        t_port1_duplex;
        t_port1_filter;
        t_stop_timer1;
        close_out;
    end

    // Whole run needs well under 8000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out;
    end
endmodule : testbench
